// ### include/nce_defines.vh
// Purpose: Constants for the nibble core execution subset
// Assumes: Opcodes are this block's own encoding of the subset
// Notes:   Definitions only
`ifndef NCE_DEFINES_VH
`define NCE_DEFINES_VH

// =====================================================================
// Operation codes on the decoded-op port
`define NCE_OP_NOP     5'h00
`define NCE_OP_SBC     5'h01
`define NCE_OP_SBE     5'h02
`define NCE_OP_SC      5'h03
`define NCE_OP_SMB     5'h04
`define NCE_OP_SMBD    5'h05
`define NCE_OP_SUBC    5'h06
`define NCE_OP_SUBCB   5'h07
`define NCE_OP_SUB_BSKIP 5'h08
`define NCE_OP_SUB_SKIP  5'h09
`define NCE_OP_SUBSB   5'h0a
`define NCE_OP_TAB     5'h0b
`define NCE_OP_TC      5'h0c
`define NCE_OP_TMB     5'h0d
`define NCE_OP_TMBD    5'h0e
`define NCE_OP_XAB     5'h0f
`define NCE_OP_XAM     5'h10
`define NCE_OP_XAMB    5'h11
`define NCE_OP_XAMD    5'h12
`define NCE_OP_XAMDB   5'h13
`define NCE_OP_XAMM    5'h14
`define NCE_OP_XINC    5'h15
`define NCE_OP_XDEC    5'h16
`define NCE_OP_RTI     5'h17
`define NCE_OP_JMP     5'h18
`define NCE_OP_TBLJ    5'h19

// =====================================================================
// Data memory map, bank 0
`define NCE_STKPTR_HI_ADDR 8'h7f
`define NCE_STKPTR_LO_ADDR 8'h7e
`define NCE_MIE_ADDR    8'h7c
`define NCE_MIE_BIT     0

// =====================================================================
// Bank select byte fields, reset values and RTI cycle count
`define NCE_BSB_ENABLE  7
`define NCE_BSB_COMMON  3
`define NCE_BSB_RST     8'h00
`define NCE_STKPTR_RST  8'hff
`define NCE_RTI_CYC     3'h5

`endif

// ### hdl/nce_exec.v
// Purpose: Execute a subset of a 4-bit core's instructions
// Assumes: Decoded op, immediates and bank given on i_start; data memory
//          answers a read in the same cycle that o_mem_rd is high
// Notes:   One op at a time; o_busy high while executing, but one-cycle register ops raise it only when skipped
`timescale 1ns/1ps
`include "nce_defines.vh"

module nce_exec #(
  parameter PG_W = 12
) (
  // Clock and reset
  input  wire            i_clk,
  input  wire            i_rst,
  // Decoded instruction
  input  wire            i_start,
  input  wire [4:0]      i_op,
  input  wire            i_use_secondary,
  input  wire [1:0]      i_bit,
  input  wire [7:0]      i_imm8,
  input  wire [PG_W-1:0] i_jaddr,
  input  wire [3:0]      i_bank,
  input  wire [1:0]      i_cycles,
  // Data memory
  output reg             o_mem_rd,
  output reg             o_mem_wr,
  output reg  [11:0]     o_mem_addr,
  output reg  [3:0]      o_mem_wdata,
  input  wire [3:0]      i_mem_rdata,
  // State view
  output reg             o_busy,
  output reg             o_skip,
  output reg  [3:0]      o_acc,
  output reg             o_carry,
  output reg  [7:0]      o_primary_pointer,
  output reg  [7:0]      o_secondary_pointer,
  output reg  [7:0]      o_bank_select_byte,
  output reg  [PG_W-1:0] o_program_counter
);

  // ===================================================================
  // State encoding
  localparam S_IDLE = 3'h0;
  localparam S_RD0  = 3'h1;
  localparam S_RD1  = 3'h2;
  localparam S_EXE  = 3'h3;
  localparam S_WB1  = 3'h4;
  localparam S_WAIT = 3'h5;
  localparam S_STK  = 3'h6;

  reg  [2:0]  state_q;
  reg  [4:0]  op_q;
  reg  [1:0]  bit_q;
  reg  [11:0] ea_q;
  reg  [3:0]  lo_q;
  reg  [3:0]  b_q;
  reg  [2:0]  cnt_q;
  reg  [2:0]  stk_q;
  reg  [7:0]  stkp_q;
  reg         skipping_q;
  reg         skip_pend_q;

  // ===================================================================
  // Op classes
  reg         op_plain;
  reg         op_direct;
  reg         op_byte;

  always @* begin
    op_plain  = 1'b0;
    op_direct = 1'b0;
    op_byte   = 1'b0;
    case (i_op)
      `NCE_OP_NOP,
      `NCE_OP_SBC,
      `NCE_OP_SBE,
      `NCE_OP_SC,
      `NCE_OP_TC,
      `NCE_OP_TAB,
      `NCE_OP_XAB,
      `NCE_OP_JMP,
      `NCE_OP_TBLJ: begin
        // Register-only ops, done on the taking edge
        op_plain = 1'b1;
      end
      `NCE_OP_SMBD,
      `NCE_OP_TMBD,
      `NCE_OP_XAMD: begin
        op_direct = 1'b1;
      end
      `NCE_OP_SUBCB,
      `NCE_OP_SUBSB,
      `NCE_OP_XAMB: begin
        op_byte = 1'b1;
      end
      `NCE_OP_XAMDB: begin
        op_direct = 1'b1;
        op_byte   = 1'b1;
      end
      default: begin
        op_plain = 1'b0;
      end
    endcase
  end

  // ===================================================================
  // Combinational helpers
  wire [7:0]  byte_acc = {b_q, o_acc};
  wire [3:0]  h_n      = o_primary_pointer[7:4];
  wire [3:0]  l_n      = o_primary_pointer[3:0];
  wire [7:0]  ptr      = i_use_secondary ? o_secondary_pointer
                                         : o_primary_pointer;
  wire [7:0]  lo8      = op_direct ? i_imm8 : ptr;
  wire        is_byte  = op_byte;
  wire [7:0]  mbyte    = {i_mem_rdata, lo_q};
  wire [4:0]  sub4c    = {1'b0, o_acc} - {1'b0, i_mem_rdata} - {4'h0, o_carry};
  wire [4:0]  sub4     = {1'b0, o_acc} - {1'b0, i_mem_rdata};
  wire [8:0]  sub8c    = {1'b0, byte_acc} - {1'b0, mbyte} - {8'h00, o_carry};
  wire [8:0]  sub8     = {1'b0, byte_acc} - {1'b0, mbyte};
  wire [3:0]  l_inc    = l_n + 4'h1;
  wire [3:0]  l_dec    = l_n - 4'h1;
  wire [3:0]  mask     = 4'h1 << bit_q;

  // ===================================================================
  // Execution
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q             <= S_IDLE;
      op_q                <= `NCE_OP_NOP;
      bit_q               <= 2'h0;
      ea_q                <= 12'h000;
      lo_q                <= 4'h0;
      b_q                 <= 4'h0;
      cnt_q               <= 3'h0;
      stk_q               <= 3'h0;
      stkp_q              <= `NCE_STKPTR_RST;
      skipping_q          <= 1'b0;
      skip_pend_q         <= 1'b0;
      o_mem_rd            <= 1'b0;
      o_mem_wr            <= 1'b0;
      o_mem_addr          <= 12'h000;
      o_mem_wdata         <= 4'h0;
      o_busy              <= 1'b0;
      o_skip              <= 1'b0;
      o_acc               <= 4'h0;
      o_carry             <= 1'b0;
      o_primary_pointer   <= 8'h00;
      o_secondary_pointer <= 8'h00;
      o_bank_select_byte  <= `NCE_BSB_RST;
      o_program_counter   <= {PG_W{1'b0}};
    end else begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_skip   <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (i_start) begin
            op_q   <= i_op;
            bit_q  <= i_bit;
            o_busy <= 1'b1;
            ea_q   <= {i_bank, is_byte ? {lo8[7:1], 1'b0} : lo8};
            if (skip_pend_q) begin
              // Skipped op only burns its cycles
              skip_pend_q <= 1'b0;
              skipping_q  <= 1'b1;
              cnt_q       <= {1'b0, i_cycles};
              state_q     <= S_WAIT;
            end else begin
              skipping_q <= 1'b0;
              state_q <= S_EXE;
              case (i_op)
                `NCE_OP_SBC: o_bank_select_byte[`NCE_BSB_COMMON] <= 1'b1;
                `NCE_OP_SBE: o_bank_select_byte[`NCE_BSB_ENABLE] <= 1'b1;
                `NCE_OP_SC:  o_carry <= 1'b1;
                `NCE_OP_TC:  skip_pend_q <= o_carry;
                `NCE_OP_TAB: skip_pend_q <= o_acc[i_bit];
                `NCE_OP_XAB: begin
                  o_acc <= b_q;
                  b_q   <= o_acc;
                end
                `NCE_OP_JMP:  o_program_counter <= i_jaddr;
                `NCE_OP_TBLJ: o_program_counter <= {i_jaddr[PG_W-9:0], 8'h00};
                `NCE_OP_RTI: begin
                  stk_q      <= 3'h0;
                  o_mem_rd   <= 1'b1;
                  o_mem_addr <= {4'h0, stkp_q[7:1], 1'b0} + 12'h001;
                  state_q    <= S_STK;
                end
                default: begin
                  o_mem_rd   <= 1'b1;
                  o_mem_addr <= {i_bank, is_byte ? {lo8[7:1], 1'b0} : lo8};
                  state_q    <= is_byte ? S_RD0 : S_EXE;
                end
              endcase
              if (op_plain) begin
                // Longer register ops idle out their remaining cycles
                if (i_cycles > 2'h1) begin
                  cnt_q   <= {1'b0, i_cycles - 2'h1};
                  state_q <= S_WAIT;
                  o_busy  <= 1'b1;
                end else begin
                  cnt_q   <= 3'h0;
                  state_q <= S_IDLE;
                  o_busy  <= 1'b0;
                end
              end
            end
          end
        end
        S_RD0: begin
          // Even nibble arrives, fetch the odd one
          lo_q       <= i_mem_rdata;
          o_mem_rd   <= 1'b1;
          o_mem_addr <= ea_q + 12'h001;
          state_q    <= S_EXE;
        end
        S_EXE: begin
          state_q     <= S_IDLE;
          o_busy      <= 1'b0;
          o_mem_addr  <= ea_q;
          case (op_q)
            `NCE_OP_SMB, `NCE_OP_SMBD: begin
              o_mem_wr    <= 1'b1;
              o_mem_wdata <= i_mem_rdata | mask;
            end
            `NCE_OP_TMB, `NCE_OP_TMBD: skip_pend_q <= i_mem_rdata[bit_q];
            `NCE_OP_SUBC: begin
              o_acc   <= sub4c[3:0];
              o_carry <= sub4c[4];
            end
            `NCE_OP_SUB_BSKIP: begin
              o_acc       <= sub4c[3:0];
              o_carry     <= sub4c[4];
              skip_pend_q <= ~sub4c[4];
            end
            `NCE_OP_SUB_SKIP: begin
              o_acc       <= sub4[3:0];
              skip_pend_q <= sub4[4];
            end
            `NCE_OP_SUBCB: begin
              {b_q, o_acc} <= sub8c[7:0];
              o_carry      <= sub8c[8];
            end
            `NCE_OP_SUBSB: begin
              {b_q, o_acc} <= sub8[7:0];
              skip_pend_q  <= sub8[8];
            end
            `NCE_OP_XAM, `NCE_OP_XAMD, `NCE_OP_XAMM, `NCE_OP_XINC, `NCE_OP_XDEC: begin
              o_acc       <= i_mem_rdata;
              o_mem_wr    <= 1'b1;
              o_mem_wdata <= o_acc;
              if (op_q == `NCE_OP_XAMM)
                o_primary_pointer[7:4] <= h_n ^ {2'h0, bit_q};
              if (op_q == `NCE_OP_XINC) begin
                o_primary_pointer[3:0] <= l_inc;
                skip_pend_q            <= (l_inc == 4'h0);
                state_q                <= S_WAIT;
                o_busy                 <= 1'b1;
                cnt_q                  <= 3'h0;
              end
              if (op_q == `NCE_OP_XDEC) begin
                o_primary_pointer[3:0] <= l_dec;
                skip_pend_q            <= (l_dec == 4'hf);
                state_q                <= S_WAIT;
                o_busy                 <= 1'b1;
                cnt_q                  <= 3'h0;
              end
            end
            `NCE_OP_XAMB, `NCE_OP_XAMDB: begin
              {b_q, o_acc} <= mbyte;
              o_mem_wr     <= 1'b1;
              o_mem_wdata  <= o_acc;
              lo_q         <= b_q;
              state_q      <= S_WB1;
              o_busy       <= 1'b1;
            end
            default: ;
          endcase
        end
        S_WB1: begin
          o_mem_wr    <= 1'b1;
          o_mem_addr  <= ea_q + 12'h001;
          o_mem_wdata <= lo_q;
          o_busy      <= 1'b0;
          state_q     <= S_IDLE;
        end
        S_WAIT: begin
          if (cnt_q <= 3'h1) begin
            o_busy  <= 1'b0;
            state_q <= S_IDLE;
            // Only a skipped op reports the pulse, not a long plain op
            o_skip  <= skipping_q;
          end
          cnt_q <= cnt_q - 3'h1;
        end
        S_STK: begin
          // Walk down from the top: PC(3 nibbles), C; HL gets the PC-low and C nibbles via BA
          stk_q <= stk_q + 3'h1;
          if (stk_q != 3'h4) begin
            o_mem_rd   <= 1'b1;
            o_mem_addr <= o_mem_addr - 12'h001;
          end
          case (stk_q)
            3'h0: o_program_counter[PG_W-1:8] <= i_mem_rdata[PG_W-9:0];
            3'h1: o_program_counter[7:4]      <= i_mem_rdata;
            3'h2: o_program_counter[3:0]      <= i_mem_rdata;
            3'h3: o_carry                     <= i_mem_rdata[0];
            default: begin
              o_primary_pointer <= {b_q, o_acc};
              stkp_q            <= stkp_q + 8'h04;
              o_mem_wr          <= 1'b1;
              o_mem_addr        <= {4'h0, `NCE_MIE_ADDR};
              o_mem_wdata       <= 4'h1 << `NCE_MIE_BIT;
              o_busy            <= 1'b0;
              state_q           <= S_IDLE;
            end
          endcase
          if (stk_q == 3'h2)
            b_q <= i_mem_rdata;
          if (stk_q == 3'h3)
            o_acc <= i_mem_rdata;
        end
        default: state_q <= S_IDLE;
      endcase
      stkp_q[0] <= 1'b1;
    end
  end

endmodule // nce_exec

// ### dv/nce_exec_assertions.sv
// Purpose: Port checks for nce_exec
// Assumes: Bench holds op inputs steady until the next start
// Notes:   Bound into every nce_exec
`timescale 1ns/1ps
`include "nce_defines.vh"

module nce_exec_checker #(
  parameter PG_W = 12
) (
  // Watched ports
  input wire            i_clk,
  input wire            i_rst,
  input wire            i_start,
  input wire [4:0]      i_op,
  input wire            i_use_secondary,
  input wire [7:0]      i_imm8,
  input wire            o_busy,
  input wire            o_skip,
  input wire            o_mem_rd,
  input wire [11:0]     o_mem_addr,
  input wire [3:0]      o_acc,
  input wire            o_carry,
  input wire [7:0]      o_primary_pointer,
  input wire [7:0]      o_bank_select_byte,
  input wire [PG_W-1:0] o_program_counter
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // =====================================================================
  // Checks
  a_start_busy: assert property (i_start && !o_busy && (i_op == `NCE_OP_SUBC
    || i_op == `NCE_OP_RTI) |=> o_busy) else $error("start not taken");
  a_busy_bound: assert property ($rose(o_busy) |-> ##[1:8] !o_busy)
    else $error("op never ends");
  a_idle_hold: assert property (!o_busy && !i_start |=> $stable(o_acc) && $stable(o_carry)
    && $stable(o_primary_pointer) && $stable(o_bank_select_byte)
    && $stable(o_program_counter)) else $error("state moved while idle");
  a_skip_noeff: assert property (o_skip |-> $stable(o_acc) && $stable(o_carry)
    && $stable(o_primary_pointer)) else $error("skipped op had effect");
  a_skip_pulse: assert property (o_skip |=> !o_skip)
    else $error("skip flag too long");
  a_rd_busy: assert property (o_mem_rd |-> o_busy)
    else $error("read while idle");
  a_primary_addr: assert property (o_mem_rd && !i_use_secondary && (i_op == `NCE_OP_SUBC
    || i_op == `NCE_OP_SUB_SKIP) |-> o_mem_addr[7:0] == o_primary_pointer)
    else $error("indirect address not primary pointer");
  a_direct_addr: assert property (o_mem_rd && i_op == `NCE_OP_TMBD
    |-> o_mem_addr[7:0] == i_imm8) else $error("direct address wrong");
endmodule // nce_exec_checker

bind nce_exec nce_exec_checker #(.PG_W(PG_W)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_op(i_op),
  .i_use_secondary(i_use_secondary),
  .i_imm8(i_imm8), .o_busy(o_busy), .o_skip(o_skip), .o_mem_rd(o_mem_rd),
  .o_mem_addr(o_mem_addr), .o_acc(o_acc), .o_carry(o_carry),
  .o_primary_pointer(o_primary_pointer), .o_bank_select_byte(o_bank_select_byte),
  .o_program_counter(o_program_counter));

// ### dv/nce_exec_test.sv
// Purpose: Self-checking bench for nce_exec
// Assumes: Bench acts as data memory
// Notes:   Bank 2, direct address 35
`timescale 1ns/1ps
`include "nce_defines.vh"

module nce_exec_test;
  reg         i_clk, i_rst, i_start, i_use_secondary;
  reg  [4:0]  i_op;
  reg  [1:0]  i_bit, i_cycles;
  reg  [7:0]  i_imm8;
  reg  [11:0] i_jaddr;
  reg  [3:0]  i_bank;
  wire [3:0]  i_mem_rdata;
  wire        o_mem_rd, o_mem_wr, o_busy, o_skip, o_carry;
  wire [11:0] o_mem_addr, o_program_counter;
  wire [3:0]  o_mem_wdata, o_acc;
  wire [7:0]  o_primary_pointer, o_secondary_pointer, o_bank_select_byte;
  reg  [3:0]  mem [0:4095];
  integer     errors, compares, cyc, i;
  reg         saw_skip;
  reg  [3:0]  a0;

  nce_exec #(.PG_W(12)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_op(i_op),
    .i_use_secondary(i_use_secondary),
    .i_bit(i_bit), .i_imm8(i_imm8), .i_jaddr(i_jaddr), .i_bank(i_bank),
    .i_cycles(i_cycles), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
    .o_busy(o_busy), .o_skip(o_skip), .o_acc(o_acc), .o_carry(o_carry),
    .o_primary_pointer(o_primary_pointer), .o_secondary_pointer(o_secondary_pointer),
    .o_bank_select_byte(o_bank_select_byte), .o_program_counter(o_program_counter));

  // =====================================================================
  // Clock, memory, watchdog
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Read data stand while the registered read strobe is high
  assign i_mem_rdata = (o_mem_rd === 1'b1) ? mem[o_mem_addr] : 4'h5;

  always @(posedge i_clk) begin
    if (o_mem_wr === 1'b1) mem[o_mem_addr] <= o_mem_wdata;
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      conclude;
    end
  end

  // =====================================================================
  // Shared tasks
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task run(input logic [4:0] op, input logic [1:0] b, input logic sec);
    integer n;
    begin
      @(posedge i_clk);
      i_start <= 1'b1;
      i_op <= op;
      i_bit <= b;
      i_use_secondary <= sec;
      @(posedge i_clk);
      i_start <= 1'b0;
      saw_skip = 1'b0;
      n = 0;
      #1;
      while (o_busy !== 1'b0 && n < 20) begin
        @(posedge i_clk);
        #1;
        n = n + 1;
        if (o_skip === 1'b1) saw_skip = 1'b1;
      end
      chk(n < 20, 1'b1);
      // Let a registered write reach the memory
      @(posedge i_clk);
      #1;
    end
  endtask

  task conclude;
    begin
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  // =====================================================================
  // Scenarios
  task t_flags;
    begin
      chk(o_bank_select_byte, 8'h00);
      chk(o_secondary_pointer, 8'h00);
      chk({o_acc, o_carry, o_primary_pointer}, 13'h0);
      run(`NCE_OP_SBC, 2'h0, 1'b0);
      chk(o_bank_select_byte, 8'h08);
      run(`NCE_OP_SBE, 2'h0, 1'b0);
      chk(o_bank_select_byte, 8'h88);
      run(`NCE_OP_SC, 2'h0, 1'b0);
      chk(o_carry, 1'b1);
    end
  endtask

  task t_sub;
    begin
      mem[12'h200] = 4'h3;
      run(`NCE_OP_SUBC, 2'h0, 1'b0);
      chk({o_acc, o_carry}, 5'h19);
      mem[12'h200] = 4'h5;
      run(`NCE_OP_SUB_SKIP, 2'h0, 1'b0);
      chk({o_acc, o_carry}, 5'h0f);
      mem[12'h200] = 4'h9;
      run(`NCE_OP_SUB_SKIP, 2'h0, 1'b0);
      chk(o_acc, 4'he);
      run(`NCE_OP_XAM, 2'h0, 1'b0);
      chk({saw_skip, o_acc, mem[12'h200]}, 9'h1e9);
      run(`NCE_OP_SUB_BSKIP, 2'h0, 1'b0);
      chk({o_acc, o_carry}, 5'h08);
      run(`NCE_OP_SC, 2'h0, 1'b0);
      chk({saw_skip, o_carry}, 2'h2);
    end
  endtask

  task t_test;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        run(`NCE_OP_TAB, i[1:0], 1'b0);
        run(`NCE_OP_TC, 2'h0, 1'b0);
        chk(saw_skip, i == 2);
      end
      mem[12'h235] = 4'h8;
      run(`NCE_OP_TMBD, 2'h3, 1'b0);
      run(`NCE_OP_NOP, 2'h0, 1'b0);
      chk(saw_skip, 1'b1);
      run(`NCE_OP_SC, 2'h0, 1'b0);
      run(`NCE_OP_TC, 2'h0, 1'b0);
      run(`NCE_OP_NOP, 2'h0, 1'b0);
      chk(saw_skip, 1'b1);
    end
  endtask

  task t_xchg;
    begin
      run(`NCE_OP_XINC, 2'h0, 1'b0);
      chk({o_acc, mem[12'h200], o_primary_pointer}, 16'h9401);
      for (i = 1; i < 16; i = i + 1) run(`NCE_OP_XINC, 2'h0, 1'b0);
      run(`NCE_OP_NOP, 2'h0, 1'b0);
      chk({saw_skip, o_primary_pointer}, 9'h100);
      run(`NCE_OP_XDEC, 2'h0, 1'b0);
      run(`NCE_OP_NOP, 2'h0, 1'b0);
      chk({saw_skip, o_primary_pointer}, 9'h10f);
      a0 = o_acc;
      mem[12'h200] = 4'h1;
      mem[12'h20f] = 4'h7;
      run(`NCE_OP_SUB_SKIP, 2'h0, 1'b1);
      a0 = a0 - 4'h1;
      chk(o_acc, a0);
    end
  endtask

  task t_jump;
    begin
      i_jaddr <= 12'h5a3;
      run(`NCE_OP_JMP, 2'h0, 1'b0);
      chk(o_program_counter, 12'h5a3);
      i_jaddr <= 12'h007;
      run(`NCE_OP_TBLJ, 2'h0, 1'b0);
      chk(o_program_counter, 12'h700);
      mem[12'h0ff] = 4'h1;
      mem[12'h0fe] = 4'h2;
      mem[12'h0fd] = 4'h3;
      mem[12'h0fc] = 4'h5;
      run(`NCE_OP_RTI, 2'h0, 1'b0);
      chk({o_program_counter, mem[12'h07c]}, 16'h1231);
      chk({o_carry, o_primary_pointer}, 9'h135);
    end
  endtask

  initial begin
    errors = 0;
    compares = 0;
    cyc = 0;
    i_rst = 1'b1;
    i_start = 1'b0;
    i_use_secondary = 1'b0;
    i_op = 5'h00;
    i_bit = 2'h0;
    i_cycles = 2'h1;
    i_imm8 = 8'h35;
    i_jaddr = 12'h000;
    i_bank = 4'h2;
    for (i = 0; i < 4096; i = i + 1) mem[i] = 4'h0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    t_flags;
    t_sub;
    t_test;
    t_xchg;
    t_jump;
    conclude;
  end
endmodule // nce_exec_test
